//--- bench/hiccup_fault_counter_sync_pwm_gate_tb.sv
// Self-checking bench for the switching-cycle supervisor
module hiccup_fault_counter_sync_pwm_gate_tb
	import gate_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic fault_en = 1'b0;
	logic sync_en = 1'b0;
	logic ramp_ok = 1'b1;
	logic hic_q = 1'b0;
	pin_in_type pins;
	gate_type gate_drive;
	logic [2:0] fault_count;
	logic hiccup_active;
	logic undervoltage_lockout;
	logic sync_locked;
	int error_cnt = 0;
	int tests_run = 0;
	int n;
	int m;

	always #50 core_clk = ~core_clk;

	cycle_supervisor dut(.core_clk, .rst, .pins, .gate_drive, .fault_count,
		.hiccup_active, .undervoltage_lockout, .sync_locked);
	switch_model model(.core_clk, .gate_drive, .fault_en, .sync_en,
		.ramp_ok, .pins);

	// ****************************************
	// Helpers
	// ****************************************
	task close_out;
		if (error_cnt == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	task fail(input string s, input logic v);
		error_cnt++;
		$display("[FAIL] %s exp %b got timeout", s, v);
		close_out();
	endtask : fail

	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %0h got %0h", s, e, g);
		end
	endtask : chk

	task tick(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask : tick

	function automatic logic sig(input int k);
		case (k)
			0: return gate_drive.high_on;
			1: return hiccup_active;
			2: return undervoltage_lockout;
			3: return sync_locked;
			default: return pins.sync;
		endcase
	endfunction : sig

	task automatic wait_for(input int k, input logic v, input int lim,
		output int c);
		c = 0;
		while (sig(k) !== v) begin
			tick(1);
			c++;
			if (c > lim) fail("wait", v);
		end
	endtask : wait_for

	// Clocks from one high-side turn-on to the next
	task automatic rise(output int c);
		int a;
		int b;
		wait_for(0, 1'b0, 200, a);
		wait_for(0, 1'b1, 200, b);
		c = a + b;
	endtask : rise

	task automatic step_cnt(input logic [2:0] e);
		logic [2:0] o;
		int c;
		o = fault_count;
		c = 0;
		while (fault_count === o) begin
			tick(1);
			c++;
			if (c > 60) fail("fault_count", 1'b1);
		end
		chk("fault_count", 8'(e), 8'(fault_count));
	endtask : step_cnt

	// Gates must stay off once the restart has settled for one edge
	always @(posedge core_clk) begin
		if (hic_q === 1'b1 && hiccup_active === 1'b1) begin
			tests_run++;
			if (gate_drive !== 2'b00) begin
				error_cnt++;
				$display("[FAIL] gates exp 0 got %b", gate_drive);
			end
		end
		hic_q <= hiccup_active;
	end

	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		chk("fault_count", 8'(FAULT_RESET), 8'(fault_count));
		chk("hiccup", 8'h01, 8'(hiccup_active));
		chk("uv", 8'h00, 8'(undervoltage_lockout));
	endtask : t_reset

	task t_soft;
		for (int k = 6; k >= 0; k--) step_cnt(3'(k));
		tick(2);
		chk("hiccup", 8'h00, 8'(hiccup_active));
	endtask : t_soft

	task t_free;
		rise(n);
		rise(n);
		chk("free period", 8'(OSC_CYC), 8'(n));
	endtask : t_free

	// Overcurrent from the first clock of the pulse, held throughout
	task t_oc;
		rise(n);
		fault_en = 1'b1;
		wait_for(0, 1'b0, 8, n);
		chk("cutoff", 8'h03, 8'(n));
		wait_for(0, 1'b1, 60, m);
		chk("off to next", 8'(OSC_CYC), 8'(n + m));
		chk("fault_count", 8'h01, 8'(fault_count));
		for (int k = 2; k <= 7; k++) step_cnt(3'(k));
		tick(2);
		chk("hiccup", 8'h01, 8'(hiccup_active));
		for (int k = 6; k >= 0; k--) step_cnt(3'(k));
		for (int k = 1; k <= 7; k++) step_cnt(3'(k));
		tick(2);
		chk("hiccup", 8'h01, 8'(hiccup_active));
		fault_en = 1'b0;
		for (int k = 6; k >= 0; k--) step_cnt(3'(k));
	endtask : t_oc

	task t_floor;
		fault_en = 1'b1;
		for (int k = 1; k <= 3; k++) step_cnt(3'(k));
		fault_en = 1'b0;
		for (int k = 2; k >= 0; k--) step_cnt(3'(k));
		tick(100);
		chk("fault_count", 8'h00, 8'(fault_count));
	endtask : t_floor

	task t_sync;
		sync_en = 1'b1;
		wait_for(3, 1'b1, 150, n);
		rise(n);
		rise(n);
		chk("sync period", 8'h20, 8'(n));
		wait_for(4, 1'b1, 40, n);
		wait_for(4, 1'b0, 40, n);
		wait_for(0, 1'b1, 40, m);
		chk("sync to pulse", 8'h04, 8'(m));
	endtask : t_sync

	task t_loss;
		sync_en = 1'b0;
		wait_for(3, 1'b0, 200, n);
		rise(n);
		rise(n);
		chk("free period", 8'(OSC_CYC), 8'(n));
	endtask : t_loss

	// Limit lies far below seven long-ramp cycles
	task t_sync_uv;
		ramp_ok = 1'b0;
		sync_en = 1'b1;
		wait_for(2, 1'b1, 80, n);
		tick(2);
		chk("gates", 8'h00, 8'(gate_drive));
	endtask : t_sync_uv

	task t_long_ramp;
		rst = 1'b1;
		sync_en = 1'b0;
		tick(2);
		rst = 1'b0;
		tick(220);
		chk("uv early", 8'h00, 8'(undervoltage_lockout));
		wait_for(2, 1'b1, 120, n);
	endtask : t_long_ramp

	initial begin
		tick(5);
		rst = 1'b0;
		t_reset();
		t_soft();
		t_free();
		t_oc();
		t_floor();
		t_sync();
		t_loss();
		t_sync_uv();
		t_long_ramp();
		close_out();
	end
endmodule : hiccup_fault_counter_sync_pwm_gate_tb

//--- bench/switch_model.sv
// Gate driver, current comparator, ramp and sync source model
module switch_model
	import gate_pkg::*;
#(
	parameter int SYNC_CYC = 32,
	parameter int DUTY = 12
)
(
	// Clock
	input wire logic core_clk,
	// Gates and scenario controls
	input wire gate_type gate_drive,
	input wire logic fault_en,
	input wire logic sync_en,
	input wire logic ramp_ok,
	// Pins to the block
	output pin_in_type pins
);
	timeunit 1ns;
	timeprecision 1ns;
	int sc = 0;
	int hc = 0;
	always @(posedge core_clk) begin
		sc <= (sc + 1) % SYNC_CYC;
		hc <= gate_drive.high_on ? hc + 1 : 0;
	end
	// Sync is pulled low when the source is off; 32 clocks against 40
	// Drop is only visible while the high side conducts
	assign pins = '{sync: sync_en && (sc < SYNC_CYC / 2),
		overcurrent: fault_en && gate_drive.high_on,
		ramp_done: ramp_ok,
		duty_end: hc >= DUTY};
endmodule : switch_model

//--- hdl/cycle_supervisor.sv
// Pulse cut-off, hiccup fault counter, sync selection and gate control
module cycle_supervisor
	import gate_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Comparator, ramp and sync pins (asynchronous)
	input wire pin_in_type pins,
	// Gate drive
	output gate_type gate_drive,
	// Status
	output logic [2:0] fault_count,
	output logic hiccup_active,
	output logic undervoltage_lockout,
	output logic sync_locked
);

	// ********************************************************
	// Pin synchronisation
	// ********************************************************
	pin_in_type pins_s;

	pin_sync u_pin_sync (
		.core_clk(core_clk),
		.rst(rst),
		.pin_async(pins),
		.pin_sync_out(pins_s)
	);

	// Saturating up/down step of a 3-bit counter
	function automatic logic [2:0] step3(input logic [2:0] v,
		input logic up);
		logic [2:0] r;
		r = v;
		if (up) begin
			if (v != FAULT_LIMIT) begin
				r = v + CNT_ONE;
			end
		end else begin
			if (v != CNT_ZERO) begin
				r = v - CNT_ONE;
			end
		end
		return r;
	endfunction : step3

	// ********************************************************
	// Cycle timing: oscillator and sync selection
	// ********************************************************
	logic sync_prev_r;
	logic sync_prev_nxt;
	logic [6:0] osc_cnt_r;
	logic [6:0] osc_cnt_nxt;
	logic [7:0] loss_cnt_r;
	logic [7:0] loss_cnt_nxt;
	logic sync_mode_r;
	logic sync_mode_nxt;
	logic sync_fall;
	logic osc_wrap;
	logic cycle_start;

	assign sync_fall = sync_prev_r & ~pins_s.sync;
	assign osc_wrap = (osc_cnt_r == OSC_CYC - 7'h01);
	// The oscillator only times cycles while not locked to sync (sync_mode_r low)
	assign cycle_start = sync_fall | (~sync_mode_r & osc_wrap);

	always_comb begin
		sync_prev_nxt = pins_s.sync;
		osc_cnt_nxt = osc_cnt_r;
		if (cycle_start) begin
			osc_cnt_nxt = OSC_RESET;
		end else if (!osc_wrap) begin
			osc_cnt_nxt = osc_cnt_r + 7'h01;
		end
		loss_cnt_nxt = loss_cnt_r;
		sync_mode_nxt = sync_mode_r;
		if (sync_fall) begin
			loss_cnt_nxt = LOSS_RESET;
			sync_mode_nxt = 1'b1;
		end else if (loss_cnt_r == SYNC_LOSS_CYC - 8'h01) begin
			// Pin held low or stopped: fall back to the oscillator
			sync_mode_nxt = 1'b0;
		end else begin
			loss_cnt_nxt = loss_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync_prev_r <= 1'b0;
			osc_cnt_r <= OSC_RESET;
			loss_cnt_r <= LOSS_RESET;
			sync_mode_r <= 1'b0;
		end else begin
			sync_prev_r <= sync_prev_nxt;
			osc_cnt_r <= osc_cnt_nxt;
			loss_cnt_r <= loss_cnt_nxt;
			sync_mode_r <= sync_mode_nxt;
		end
	end

	// ********************************************************
	// Fault counter, undervoltage and gate control
	// ********************************************************
	mode_type mode_r;
	mode_type mode_nxt;
	logic [2:0] fault_r;
	logic [2:0] fault_nxt;
	logic [2:0] uv_cnt_r;
	logic [2:0] uv_cnt_nxt;
	logic oc_seen_r;
	logic oc_seen_nxt;
	logic ramp_seen_r;
	logic ramp_seen_nxt;
	logic arm_r;
	logic arm_nxt;
	logic hs_r;
	logic hs_nxt;
	logic ls_r;
	logic ls_nxt;
	logic oc_now;
	logic ramp_ok;
	logic overrun;
	logic sync_cut;
	logic run_nxt;

	// The ramp must have finished before the next cycle begins
	assign oc_now = oc_seen_r | (hs_r & pins_s.overcurrent);
	assign ramp_ok = ramp_seen_r | pins_s.ramp_done;
	assign overrun = cycle_start & ~ramp_ok;
	assign sync_cut = sync_fall & ~ramp_ok;

	always_comb begin
		mode_nxt = mode_r;
		fault_nxt = fault_r;
		uv_cnt_nxt = uv_cnt_r;
		oc_seen_nxt = oc_seen_r;
		ramp_seen_nxt = ramp_seen_r;
		if (cycle_start) begin
			oc_seen_nxt = 1'b0;
			ramp_seen_nxt = 1'b0;
		end else begin
			// Overcurrent only counts while the high side conducts
			oc_seen_nxt = oc_now;
			ramp_seen_nxt = ramp_ok;
		end
		unique case (mode_r)
			MODE_RUN, MODE_HICCUP: begin
				if (sync_cut && mode_r != MODE_LOCKOUT) begin
					// Sync cut the ramp short: lock out at once
					mode_nxt = MODE_LOCKOUT;
					uv_cnt_nxt = CNT_ZERO;
				end else if (cycle_start) begin
					uv_cnt_nxt = step3(uv_cnt_r, overrun);
					if (overrun && uv_cnt_r == UV_LIMIT - CNT_ONE) begin
						mode_nxt = MODE_LOCKOUT;
						uv_cnt_nxt = CNT_ZERO;
					end else if (mode_r == MODE_RUN) begin
						fault_nxt = step3(fault_r, oc_now);
						if (oc_now && fault_r == FAULT_LIMIT - CNT_ONE) begin
							mode_nxt = MODE_HICCUP;
						end
					end else begin
						// Soft-start cycle: overcurrent is not counted
						fault_nxt = step3(fault_r, 1'b0);
						if (fault_r == CNT_ONE || fault_r == CNT_ZERO) begin
							mode_nxt = MODE_RUN;
						end
					end
				end
			end
			MODE_LOCKOUT: begin
				// Recovery needs seven good ramps, then a fresh soft-start
				if (cycle_start) begin
					uv_cnt_nxt = step3(uv_cnt_r, ~overrun);
					if (!overrun && uv_cnt_r == UV_LIMIT - CNT_ONE) begin
						mode_nxt = MODE_HICCUP;
						fault_nxt = FAULT_RESET;
						uv_cnt_nxt = CNT_ZERO;
					end
				end
			end
			default: begin
				mode_nxt = MODE_LOCKOUT;
				fault_nxt = FAULT_RESET;
				uv_cnt_nxt = CNT_ZERO;
			end
		endcase
		run_nxt = (mode_nxt == MODE_RUN);
		// Low side drops at cycle start; high side rises one clock later
		// so the two never conduct together.
		arm_nxt = cycle_start & run_nxt;
		hs_nxt = run_nxt & (arm_r | (hs_r & ~pins_s.overcurrent
			& ~pins_s.duty_end & ~cycle_start));
		ls_nxt = run_nxt & ~hs_nxt & ~hs_r & ~cycle_start & ~arm_r;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			// Start-up begins with a full soft-start sequence
			mode_r <= MODE_HICCUP;
			fault_r <= FAULT_RESET;
			uv_cnt_r <= CNT_ZERO;
			oc_seen_r <= 1'b0;
			ramp_seen_r <= 1'b0;
			arm_r <= 1'b0;
			hs_r <= 1'b0;
			ls_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			fault_r <= fault_nxt;
			uv_cnt_r <= uv_cnt_nxt;
			oc_seen_r <= oc_seen_nxt;
			ramp_seen_r <= ramp_seen_nxt;
			arm_r <= arm_nxt;
			hs_r <= hs_nxt;
			ls_r <= ls_nxt;
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	assign gate_drive.high_on = hs_r;
	assign gate_drive.low_on = ls_r;
	assign fault_count = fault_r;
	assign hiccup_active = (mode_r == MODE_HICCUP);
	assign undervoltage_lockout = (mode_r == MODE_LOCKOUT);
	assign sync_locked = sync_mode_r;

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_oc_cut;
		hs_r && pins_s.overcurrent |=> !hs_r;
	endproperty
	a_oc_cut: assert property (p_oc_cut)
		else $error("high side stayed on after overcurrent");

	property p_no_reon;
		$rose(hs_r) |-> $past(arm_r) && $past(cycle_start, 2);
	endproperty
	a_no_reon: assert property (p_no_reon)
		else $error("high side turned on outside a cycle start");

	property p_fault_inc;
		mode_r == MODE_RUN && cycle_start && oc_now && !overrun
			&& !sync_cut && fault_r != FAULT_LIMIT
		|=> fault_r == $past(fault_r) + CNT_ONE;
	endproperty
	a_fault_inc: assert property (p_fault_inc)
		else $error("fault counter did not count an overcurrent cycle");

	property p_hiccup_entry;
		mode_r == MODE_RUN && cycle_start && oc_now && !sync_cut
			&& !(overrun && uv_cnt_r == UV_LIMIT - CNT_ONE)
			&& fault_r == FAULT_LIMIT - CNT_ONE
		|=> mode_r == MODE_HICCUP && fault_r == FAULT_LIMIT
			##1 !hs_r && !ls_r;
	endproperty
	a_hiccup_entry: assert property (p_hiccup_entry)
		else $error("seventh overcurrent cycle did not start hiccup");

	property p_gates_off;
		mode_r != MODE_RUN |-> !hs_r && !ls_r;
	endproperty
	a_gates_off: assert property (p_gates_off)
		else $error("gate driven while switching disabled");

	property p_hiccup_dec;
		mode_r == MODE_HICCUP && cycle_start && !sync_cut
			&& !(overrun && uv_cnt_r == UV_LIMIT - CNT_ONE)
			&& fault_r != CNT_ZERO
		|=> fault_r == $past(fault_r) - CNT_ONE
			&& (mode_r == MODE_RUN) == (fault_r == CNT_ZERO);
	endproperty
	a_hiccup_dec: assert property (p_hiccup_dec)
		else $error("soft-start cycle did not step the counter down");

	property p_sync_start;
		sync_fall && run_nxt |=> arm_r ##1 hs_r;
	endproperty
	a_sync_start: assert property (p_sync_start)
		else $error("sync falling edge did not start a pulse");

	property p_sync_owns;
		sync_mode_r && cycle_start |-> $past(pins_s.sync) && !pins_s.sync;
	endproperty
	a_sync_owns: assert property (p_sync_owns)
		else $error("oscillator started a cycle while sync present");

	property p_free_run;
		!sync_mode_r && osc_wrap |-> cycle_start;
	endproperty
	a_free_run: assert property (p_free_run)
		else $error("oscillator wrap did not start a cycle");

	property p_uv_sync;
		sync_fall && !ramp_ok && mode_r != MODE_LOCKOUT
		|=> mode_r == MODE_LOCKOUT ##1 !hs_r;
	endproperty
	a_uv_sync: assert property (p_uv_sync)
		else $error("sync during ramp did not lock out");

	property p_uv_count;
		mode_r != MODE_LOCKOUT && overrun && uv_cnt_r == UV_LIMIT - CNT_ONE
		|=> mode_r == MODE_LOCKOUT;
	endproperty
	a_uv_count: assert property (p_uv_count)
		else $error("seventh long ramp did not declare undervoltage");

	property p_fault_floor;
		mode_r == MODE_RUN && fault_r == CNT_ZERO && cycle_start && !oc_now
		|=> fault_r == CNT_ZERO;
	endproperty
	a_fault_floor: assert property (p_fault_floor)
		else $error("fault counter went below zero");

	c_hiccup: cover property ($rose(hiccup_active) && $past(mode_r)
		== MODE_RUN);
	c_resume: cover property ($fell(hiccup_active) && !undervoltage_lockout);
	c_lockout: cover property ($rose(undervoltage_lockout));
	c_sync: cover property ($rose(sync_locked) ##[1:100] hs_r);

endmodule : cycle_supervisor

//--- hdl/pin_sync.sv
// Two-flop synchroniser for the asynchronous comparator and sync pins
module pin_sync
	import gate_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Pins
	input wire pin_in_type pin_async,
	output pin_in_type pin_sync_out
);

	pin_in_type meta_r;
	pin_in_type meta_nxt;
	pin_in_type stable_r;
	pin_in_type stable_nxt;

	// Only the second stage is read outside this module
	always_comb begin
		meta_nxt = pin_async;
		stable_nxt = meta_r;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_r <= PINS_RESET;
			stable_r <= PINS_RESET;
		end else begin
			meta_r <= meta_nxt;
			stable_r <= stable_nxt;
		end
	end

	assign pin_sync_out = stable_r;

endmodule : pin_sync

//--- pkg/gate_pkg.sv
// Constants and carrier types for the switching-cycle supervisor
package gate_pkg;

	// ********************************************************
	// Clock and switching-cycle timing
	// ********************************************************
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
	// Free-running period set by the timing resistor
	localparam int unsigned OSC_PERIOD_NS = 4000;
	localparam int unsigned OSC_CYC_INT = OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [6:0] OSC_CYC = 7'(OSC_CYC_INT);
	// Sync is considered absent after this long without a falling edge
	localparam int unsigned SYNC_LOSS_NS = 8000;
	localparam int unsigned SYNC_LOSS_INT = SYNC_LOSS_NS / CLK_PERIOD_NS;
	localparam logic [7:0] SYNC_LOSS_CYC = 8'(SYNC_LOSS_INT);

	// ********************************************************
	// Counter limits and reset values
	// ********************************************************
	localparam logic [2:0] FAULT_LIMIT = 3'h7;
	localparam logic [2:0] UV_LIMIT = 3'h7;
	localparam logic [2:0] CNT_ZERO = 3'h0;
	localparam logic [2:0] CNT_ONE = 3'h1;
	localparam logic [2:0] FAULT_RESET = 3'h7;
	localparam logic [6:0] OSC_RESET = 7'h00;
	localparam logic [7:0] LOSS_RESET = 8'h00;

	// ********************************************************
	// Types
	// ********************************************************
	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_HICCUP = 2'b01,
		MODE_LOCKOUT = 2'b10
	} mode_type;

	typedef struct packed {
		logic sync;
		logic overcurrent;
		logic ramp_done;
		logic duty_end;
	} pin_in_type;

	typedef struct packed {
		logic high_on;
		logic low_on;
	} gate_type;

	localparam pin_in_type PINS_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage : gate_pkg
